// *** cbx_map.svh ***
// constants for the branch, increment, or and shift execution block
// Notes on behaviour
// [RL1] A jump loads its 11-bit immediate (0 to 2047) into program counter bits 10 to 0.
// [RL2] A jump fills program counter bits 14 to 11 from upper-pc holding bits 6 to 3.
// [RL3] A jump takes two instruction cycles and leaves zero and carry alone.
// [RL4] Register operations address file registers 0 to 127 with a one-bit destination.
// [RL5] Plain increment writes file value plus one to the destination and updates zero.
// [RL6] Destination 0 sends the result to the accumulator, 1 back to the file register.
// [RL7] Increment-and-skip stores its result, skips on zero in two cycles, keeps flags.
// [RL8] Increment-and-skip with a nonzero result runs the next instruction normally.
// [RL9] Literal or puts accumulator or 8-bit literal into the accumulator, updates zero.
// [RL10] Register or puts accumulator or file value into the destination, updates zero.
// [RL11] Left shift moves bit 7 to carry, bits 6..0 up one, clears bit 0, sets C and Z.
// [RL12] Left shift writes its result to the destination chosen by the selector.
// [RL13] Zero is set when the 8-bit result is zero and cleared otherwise.
// [RL14] The instruction slot after a jump or a taken skip is dropped without effect.
`ifndef CBX_MAP_SVH
`define CBX_MAP_SVH

`define CBX_DATA_W    8
`define CBX_PC_W      15
`define CBX_K_W       11
`define CBX_FADDR_W   7
`define CBX_NFREG     128
`define CBX_UPC_W     7
`define CBX_PCL_HI    6
`define CBX_PCL_LO    3
`define CBX_RST_PC    15'h0000
`define CBX_RST_W     8'h00
`define CBX_SKIP_STEP 15'h0002
`define CBX_PC_STEP   15'h0001

`endif

// *** cbx_pkg.sv ***
// types shared by the execution block
`include "cbx_map.svh"
package cbx_pkg;
   typedef enum logic [6:0] {
      CBX_OP_NOP   = 7'h01,
      CBX_OP_JUMP  = 7'h02,
      CBX_OP_INC   = 7'h04,
      CBX_OP_INCSZ = 7'h08,
      CBX_OP_IORL  = 7'h10,
      CBX_OP_IORF  = 7'h20,
      CBX_OP_LSL   = 7'h40
   } cbx_op_e;

   typedef enum logic [1:0] {
      CBX_ST_EXEC  = 2'h1,
      CBX_ST_FLUSH = 2'h2
   } cbx_st_e;

   typedef struct packed {
      cbx_st_e                   st;
      logic                      flush;
      logic [`CBX_PC_W-1:0]      pc;
      logic [`CBX_DATA_W-1:0]    w;
      logic                      z;
      logic                      c;
      logic                      fwr_en;
      logic [`CBX_FADDR_W-1:0]   fwr_addr;
      logic [`CBX_DATA_W-1:0]    fwr_data;
      logic [`CBX_DATA_W-1:0]    dbg;
   } cbx_state_s;
endpackage

// *** cbx_alu_if.sv ***
// link between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`include "cbx_map.svh"
interface cbx_alu_if;
   import cbx_pkg::*;
   cbx_op_e                op;
   logic [`CBX_DATA_W-1:0] w;
   logic [`CBX_DATA_W-1:0] f;
   logic [`CBX_DATA_W-1:0] lit;
   logic [`CBX_DATA_W-1:0] res;
   logic                   cout;
   logic                   zero;
   logic                   upd_z;
   logic                   upd_c;

   modport alu  (input op, w, f, lit,
                 output res, cout, zero, upd_z, upd_c);
   modport core (output op, w, f, lit,
                 input res, cout, zero, upd_z, upd_c);
endinterface
`default_nettype wire

// *** cbx_alu.sv ***
// combinational result and flag unit
`timescale 1ns/1ps
`default_nettype none
`include "cbx_map.svh"
module cbx_alu
   import cbx_pkg::*;
(
   // operands and results
   cbx_alu_if.alu bus
);
   // result per operation, flag update enables alongside
   always_comb begin
      bus.res   = `CBX_RST_W;
      bus.cout  = 1'b0;
      bus.upd_z = 1'b0;
      bus.upd_c = 1'b0;
      case (bus.op)
         CBX_OP_INC: begin
            bus.res   = 8'(bus.f + 8'h01); // RL5
            bus.upd_z = 1'b1;
         end
         CBX_OP_INCSZ: begin
            bus.res   = 8'(bus.f + 8'h01); // RL7
         end
         CBX_OP_IORL: begin
            bus.res   = bus.w | bus.lit; // RL9
            bus.upd_z = 1'b1;
         end
         CBX_OP_IORF: begin
            bus.res   = bus.w | bus.f; // RL10
            bus.upd_z = 1'b1;
         end
         CBX_OP_LSL: begin
            bus.res   = {bus.f[6:0], 1'b0}; // RL11
            bus.cout  = bus.f[7]; // RL11
            bus.upd_z = 1'b1;
            bus.upd_c = 1'b1;
         end
         default: begin
            bus.res   = `CBX_RST_W;
         end
      endcase
   end

   // zero tracks the full 8-bit result
   assign bus.zero = (bus.res == 8'h00); // RL13
endmodule
`default_nettype wire

// *** cbx_exec.sv ***
// execution core for jump, increment, or and left shift
`timescale 1ns/1ps
`default_nettype none
`include "cbx_map.svh"
module cbx_exec
   import cbx_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   // decoded instruction slot
   input  wire logic                      instr_valid_i,
   input  wire cbx_op_e                   op_i,
   input  wire logic [`CBX_K_W-1:0]       lit_i,
   input  wire logic [`CBX_FADDR_W-1:0]   freg_i,
   input  wire logic                      dest_i,
   // latched upper program counter bits
   input  wire logic [`CBX_UPC_W-1:0]     upc_hold_i,
   // observation read of the file registers
   input  wire logic [`CBX_FADDR_W-1:0]   dbg_addr_i,
   output logic [`CBX_DATA_W-1:0]         dbg_data_o,
   // architectural state
   output logic [`CBX_PC_W-1:0]           pc_o,
   output logic [`CBX_DATA_W-1:0]         w_o,
   output logic                           z_o,
   output logic                           c_o,
   output logic                           flush_o,
   // file register write report
   output logic                           fwr_en_o,
   output logic [`CBX_FADDR_W-1:0]        fwr_addr_o,
   output logic [`CBX_DATA_W-1:0]         fwr_data_o
);
   cbx_state_s             q_r;
   cbx_state_s             q_nxt;
   logic [`CBX_DATA_W-1:0] freg_mem [`CBX_NFREG];
   logic                   wr_now;
   logic                   exec;
   logic                   reg_op;
   cbx_alu_if              alu_bus ();

   // arithmetic unit on the shared operand link
   cbx_alu u_alu (
      .bus (alu_bus.alu)
   );

   // operands: the 7-bit address covers all 128 file registers
   assign alu_bus.op  = op_i;
   assign alu_bus.w   = q_r.w;
   assign alu_bus.f   = freg_mem[freg_i]; // RL4
   assign alu_bus.lit = lit_i[`CBX_DATA_W-1:0];

   // an instruction runs only in the execute slot
   assign exec   = instr_valid_i && (q_r.st == CBX_ST_EXEC);
   assign reg_op = (op_i == CBX_OP_INC) || (op_i == CBX_OP_INCSZ) ||
                   (op_i == CBX_OP_IORF) || (op_i == CBX_OP_LSL);

   // next state; the dropped slot changes nothing but the state
   always_comb begin
      q_nxt        = q_r;
      wr_now       = 1'b0;
      q_nxt.fwr_en = 1'b0;
      q_nxt.dbg    = freg_mem[dbg_addr_i];
      case (q_r.st)
         CBX_ST_EXEC: begin
            if (instr_valid_i) begin
               q_nxt.pc = 15'(q_r.pc + `CBX_PC_STEP); // RL8
               if (op_i == CBX_OP_JUMP) begin
                  q_nxt.pc[`CBX_K_W-1:0] = lit_i; // RL1
                  q_nxt.pc[`CBX_PC_W-1:`CBX_K_W] =
                     upc_hold_i[`CBX_PCL_HI:`CBX_PCL_LO]; // RL2
                  q_nxt.st = CBX_ST_FLUSH; // RL3
               end
               if (op_i == CBX_OP_IORL) begin
                  q_nxt.w = alu_bus.res; // RL9
               end
               if (reg_op) begin
                  if (dest_i) begin
                     wr_now         = 1'b1; // RL6
                     q_nxt.fwr_en   = 1'b1; // RL12
                     q_nxt.fwr_addr = freg_i;
                     q_nxt.fwr_data = alu_bus.res;
                  end else begin
                     q_nxt.w = alu_bus.res; // RL6
                  end
               end
               // skip: step over the next word and drop its slot
               if (op_i == CBX_OP_INCSZ && alu_bus.zero) begin
                  q_nxt.pc = 15'(q_r.pc + `CBX_SKIP_STEP); // RL7
                  q_nxt.st = CBX_ST_FLUSH; // RL7
               end
               // flags only where the unit asks, jump and skip never do
               if (alu_bus.upd_z) begin
                  q_nxt.z = alu_bus.zero; // RL13
               end
               if (alu_bus.upd_c) begin
                  q_nxt.c = alu_bus.cout; // RL11
               end
            end
         end
         CBX_ST_FLUSH: begin
            q_nxt.st = CBX_ST_EXEC; // RL14
         end
         default: begin
            q_nxt.st = CBX_ST_EXEC;
         end
      endcase
      q_nxt.flush = (q_nxt.st == CBX_ST_FLUSH);
   end

   // state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         q_r.st       <= CBX_ST_EXEC;
         q_r.flush    <= 1'b0;
         q_r.pc       <= `CBX_RST_PC;
         q_r.w        <= `CBX_RST_W;
         q_r.z        <= 1'b0;
         q_r.c        <= 1'b0;
         q_r.fwr_en   <= 1'b0;
         q_r.fwr_addr <= 7'h00;
         q_r.fwr_data <= `CBX_RST_W;
         q_r.dbg      <= `CBX_RST_W;
      end else begin
         q_r <= q_nxt;
      end
   end

   // file registers keep their contents across reset, like real ram
   always_ff @(posedge clk_i) begin
      if (rstn_i && wr_now) begin
         freg_mem[freg_i] <= alu_bus.res; // RL6
      end
   end

   // outputs straight from the state register
   assign pc_o       = q_r.pc;
   assign w_o        = q_r.w;
   assign z_o        = q_r.z;
   assign c_o        = q_r.c;
   assign flush_o    = q_r.flush;
   assign fwr_en_o   = q_r.fwr_en;
   assign fwr_addr_o = q_r.fwr_addr;
   assign fwr_data_o = q_r.fwr_data;
   assign dbg_data_o = q_r.dbg;

   // helper views for the checks below
   logic [3:0]             pcl_hi;
   logic [`CBX_DATA_W-1:0] fval;
   logic [`CBX_DATA_W-1:0] lit8;
   assign pcl_hi = upc_hold_i[`CBX_PCL_HI:`CBX_PCL_LO];
   assign fval   = alu_bus.f;
   assign lit8   = lit_i[`CBX_DATA_W-1:0];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // sequences: the one-cycle issue, then the two-step dropped slot
   sequence s_jump;
      exec && op_i == CBX_OP_JUMP;
   endsequence
   sequence s_skip_taken;
      exec && op_i == CBX_OP_INCSZ && fval == 8'hFF;
   endsequence
   sequence s_drop;
      flush_o ##1 !flush_o;
   endsequence

   property p_jump_low;
      s_jump |=> pc_o[10:0] == $past(lit_i);
   endproperty
   a_jump_low: assert property (p_jump_low) // RL1
      else $error("jump low pc bits wrong");

   property p_jump_high;
      s_jump |=> pc_o[14:11] == $past(pcl_hi);
   endproperty
   a_jump_high: assert property (p_jump_high) // RL2
      else $error("jump upper pc bits wrong");

   property p_jump_two;
      s_jump |=> s_drop and ($stable(z_o) && $stable(c_o));
   endproperty
   a_jump_two: assert property (p_jump_two) // RL3
      else $error("jump not two cycles or flags moved");

   property p_inc;
      exec && op_i == CBX_OP_INC && !dest_i |=>
         w_o == 8'($past(fval) + 8'h01) && z_o == ($past(fval) == 8'hFF);
   endproperty
   a_inc: assert property (p_inc) // RL5
      else $error("increment result or zero wrong");

   property p_dest_file;
      exec && reg_op && dest_i |=>
         fwr_en_o && fwr_addr_o == $past(freg_i) && $stable(w_o);
   endproperty
   a_dest_file: assert property (p_dest_file) // RL6
      else $error("file destination not written");

   property p_skip;
      s_skip_taken |=> s_drop and ($stable(z_o) && $stable(c_o));
   endproperty
   a_skip: assert property (p_skip) // RL7
      else $error("skip on zero not taken");

   property p_no_skip;
      exec && op_i == CBX_OP_INCSZ && fval != 8'hFF |=>
         !flush_o && pc_o == 15'($past(pc_o) + 15'h0001);
   endproperty
   a_no_skip: assert property (p_no_skip) // RL8
      else $error("nonzero increment skipped");

   property p_iorl;
      exec && op_i == CBX_OP_IORL |=>
         w_o == ($past(w_o) | $past(lit8)) && z_o == (w_o == 8'h00);
   endproperty
   a_iorl: assert property (p_iorl) // RL9
      else $error("literal or wrong");

   property p_iorf;
      exec && op_i == CBX_OP_IORF && !dest_i |=>
         w_o == ($past(w_o) | $past(fval)) && z_o == (w_o == 8'h00);
   endproperty
   a_iorf: assert property (p_iorf) // RL10
      else $error("register or wrong");

   property p_lsl;
      exec && op_i == CBX_OP_LSL && dest_i |=>
         c_o == $past(fval[7]) && fwr_data_o == {$past(fval[6:0]), 1'b0} &&
         z_o == (fwr_data_o == 8'h00);
   endproperty
   a_lsl: assert property (p_lsl) // RL11
      else $error("left shift result or carry wrong");

   property p_lsl_w;
      exec && op_i == CBX_OP_LSL && !dest_i |=>
         w_o == {$past(fval[6:0]), 1'b0} && c_o == $past(fval[7]) &&
         z_o == (w_o == 8'h00) && !fwr_en_o;
   endproperty
   a_lsl_w: assert property (p_lsl_w) // RL12
      else $error("left shift destination wrong");

   property p_drop;
      flush_o |=> $stable(w_o) && $stable(z_o) && $stable(c_o) &&
         $stable(pc_o) && !fwr_en_o;
   endproperty
   a_drop: assert property (p_drop) // RL14
      else $error("dropped slot had an effect");
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the jump, increment, or and shift core
`timescale 1ns/1ps
`default_nettype none
module tb
   import cbx_pkg::*;
   ;
   // stimulus, observation and bookkeeping
   logic        clk_i;
   logic        rstn_i;
   logic        instr_valid_i;
   cbx_op_e     op_i;
   logic [10:0] lit_i;
   logic [6:0]  freg_i;
   logic        dest_i;
   logic [6:0]  upc_hold_i;
   logic [6:0]  dbg_addr_i;
   logic [7:0]  dbg_data_o;
   logic [14:0] pc_o;
   logic [7:0]  w_o;
   logic        z_o;
   logic        c_o;
   logic        flush_o;
   logic        fwr_en_o;
   logic [6:0]  fwr_addr_o;
   logic [7:0]  fwr_data_o;
   logic [14:0] pc_e;
   int          error_cnt;
   int          comparisons;

   cbx_exec uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
      .op_i(op_i), .lit_i(lit_i), .freg_i(freg_i), .dest_i(dest_i),
      .upc_hold_i(upc_hold_i), .dbg_addr_i(dbg_addr_i),
      .dbg_data_o(dbg_data_o), .pc_o(pc_o), .w_o(w_o), .z_o(z_o),
      .c_o(c_o), .flush_o(flush_o), .fwr_en_o(fwr_en_o),
      .fwr_addr_o(fwr_addr_o), .fwr_data_o(fwr_data_o)
   );

   // 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // one compare, four-state exact
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic fl(input logic z, input logic c);
      chk({z_o, c_o}, {z, c});
   endtask

   // one instruction; junk puts a file write into the slot after it
   task automatic go(input cbx_op_e op, input logic [10:0] k,
                     input logic [6:0] a, input logic d,
                     input logic skp, input logic junk);
      logic jmp;
      jmp = (op == CBX_OP_JUMP);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      op_i <= op;
      lit_i <= k;
      freg_i <= a;
      dest_i <= d;
      @(posedge clk_i);
      if (junk) begin
         op_i <= CBX_OP_INC;
         freg_i <= 7'h7F;
         dest_i <= 1'b1;
      end else begin
         instr_valid_i <= 1'b0;
      end
      pc_e = jmp ? {upc_hold_i[6:3], k} : pc_e + (skp ? 15'h2 : 15'h1);
      #1;
      chk(pc_o, pc_e);
      chk(flush_o, jmp | skp);
      if (junk) begin
         // the dropped slot must leave no trace
         @(posedge clk_i);
         instr_valid_i <= 1'b0;
         #1;
         chk(pc_o, pc_e);
         chk({flush_o, fwr_en_o}, 2'h0);
      end
   endtask

   // observation read; the first of two edges loads the data register, the address is not registered
   task automatic rd(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_i);
      dbg_addr_i <= a;
      repeat (2) @(posedge clk_i);
      #1;
      chk(dbg_data_o, v);
   endtask

   task automatic t_reset();
      #1;
      chk({pc_o, flush_o}, 16'h0);
      chk({w_o, z_o, c_o, fwr_en_o}, 11'h0);
   endtask

   task automatic t_or();
      go(CBX_OP_IORL, 11'h700, 7'h00, 1'b0, 1'b0, 1'b0);
      chk(w_o, 8'h00);
      fl(1'b1, 1'b0);
      go(CBX_OP_IORL, 11'h3A5, 7'h00, 1'b0, 1'b0, 1'b0);
      chk(w_o, 8'hA5);
      fl(1'b0, 1'b0);
      go(CBX_OP_IORL, 11'h05A, 7'h00, 1'b0, 1'b0, 1'b0);
      chk(w_o, 8'hFF);
      go(CBX_OP_IORF, 11'h0, 7'h7F, 1'b1, 1'b0, 1'b0);
      chk({fwr_en_o, fwr_addr_o, fwr_data_o}, 16'hFFFF);
      go(CBX_OP_IORF, 11'h0, 7'h00, 1'b1, 1'b0, 1'b0);
      chk({fwr_en_o, fwr_addr_o, fwr_data_o}, 16'h80FF);
      go(CBX_OP_IORF, 11'h0, 7'h00, 1'b0, 1'b0, 1'b0);
      chk({fwr_en_o, w_o}, 9'h0FF);
      fl(1'b0, 1'b0);
      rd(7'h7F, 8'hFF);
   endtask

   // skip on zero must leave both flags as they were
   task automatic t_incsz();
      go(CBX_OP_INCSZ, 11'h0, 7'h7F, 1'b0, 1'b1, 1'b1);
      chk(w_o, 8'h00);
      fl(1'b0, 1'b0);
      rd(7'h7F, 8'hFF);
      go(CBX_OP_INCSZ, 11'h0, 7'h7F, 1'b1, 1'b1, 1'b0);
      chk({fwr_en_o, fwr_addr_o, fwr_data_o}, 16'hFF00);
      go(CBX_OP_INCSZ, 11'h0, 7'h7F, 1'b1, 1'b0, 1'b0);
      chk({fwr_en_o, fwr_addr_o, fwr_data_o}, 16'hFF01);
      fl(1'b0, 1'b0);
   endtask

   task automatic t_inc();
      go(CBX_OP_INC, 11'h0, 7'h00, 1'b1, 1'b0, 1'b0);
      chk({fwr_en_o, fwr_addr_o, fwr_data_o}, 16'h8000);
      fl(1'b1, 1'b0);
      go(CBX_OP_INC, 11'h0, 7'h00, 1'b0, 1'b0, 1'b0);
      chk({fwr_en_o, w_o}, 9'h001);
      fl(1'b0, 1'b0);
      rd(7'h00, 8'h00);
      go(CBX_OP_NOP, 11'h0, 7'h00, 1'b1, 1'b0, 1'b0);
      chk({fwr_en_o, w_o, z_o, c_o}, 11'h004);
   endtask

   // walk a byte of ones out through carry
   task automatic t_lsl();
      logic [7:0] v;
      go(CBX_OP_IORL, 11'h0FF, 7'h00, 1'b0, 1'b0, 1'b0);
      go(CBX_OP_IORF, 11'h0, 7'h7F, 1'b1, 1'b0, 1'b0);
      go(CBX_OP_LSL, 11'h0, 7'h7F, 1'b0, 1'b0, 1'b0);
      chk({fwr_en_o, w_o}, 9'h0FE);
      fl(1'b0, 1'b1);
      v = 8'hFF;
      for (int i = 0; i < 8; i++) begin
         go(CBX_OP_LSL, 11'h0, 7'h7F, 1'b1, 1'b0, 1'b0);
         chk({fwr_en_o, fwr_data_o}, {1'b1, v[6:0], 1'b0});
         fl(v[6:0] == 7'h0, v[7]);
         v = {v[6:0], 1'b0};
      end
   endtask

   // jumps with flags set; holding bits 2..0 must not leak in
   task automatic t_jump();
      logic [6:0]  p[3];
      logic [10:0] k[3];
      p = '{7'h55, 7'h78, 7'h07};
      k = '{11'h5A3, 11'h7FF, 11'h000};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         upc_hold_i <= p[i];
         go(CBX_OP_JUMP, k[i], 7'h00, 1'b0, 1'b0, 1'b1);
         chk(w_o, 8'hFE);
         fl(1'b1, 1'b1);
      end
      rd(7'h7F, 8'h00);
   endtask

   task automatic finish_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      error_cnt = 0;
      comparisons = 0;
      pc_e = 15'h0;
      rstn_i = 1'b0;
      instr_valid_i = 1'b0;
      op_i = CBX_OP_NOP;
      lit_i = 11'h0;
      freg_i = 7'h0;
      dest_i = 1'b0;
      upc_hold_i = 7'h0;
      dbg_addr_i = 7'h0;
      repeat (10) @(posedge clk_i);
      t_reset();
      @(posedge clk_i);
      rstn_i <= 1'b1;
      t_or();
      t_incsz();
      t_inc();
      t_lsl();
      t_jump();
      finish_test();
   end

   // hang guard, far beyond the 82 cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
